// >>> arlt_pkg.sv
// constants and register map for the auto-reload timer with slow-osc capture
//
// Contract
// R1 - count is a low byte and a high byte forming one 16-bit value
// R2 - split bit 3 of control: 0 one 16-bit timer, 1 two 8-bit timers
// R3 - count advances on core clock, core clock / 12, or external clock / 8
// R4 - the divided external tick is synchronised to the core clock first
// R5 - 16-bit rollover from 0xffff loads the reload pair, sets high flag
// R6 - 16-bit mode: timer interrupt enabled raises request on each overflow
// R7 - with low-byte irq enable too, low byte 0xff to 0x00 also interrupts
// R8 - split mode: each byte reloads from its own reload register
// R9 - split mode: run bit gates only the high byte, low byte always counts
// R10 - per byte: clock select 1 is core clock, else ext select picks /12 or /8
// R11 - split mode: each byte rollover sets its own overflow flag
// R12 - split mode: high overflow interrupts; with low enable, either byte does
// R13 - overflow flags are never cleared by hardware, only by software writes
// R14 - handler reads both flags to find which byte caused the interrupt
// R15 - software clears split before enabling capture, capture uses 16 bits
// R16 - capture: slow osc falling edge copies count to reload, sets high flag
// R17 - capture mode clock chosen by low-byte clock select and ext select
// R18 - software derives osc frequency from successive capture differences
// R19 - control bits: 7 hi flag, 6 lo flag, 5 lo irq en, 4 cap, 3 split, 2 run, 0 ext
// R20 - control bit 1 reads zero, writes to it are ignored
// R21 - slow osc is synchronised, falling edge gives one single-cycle strobe
// R22 - reload happens in the overflowing tick cycle, zero is never counted
package arlt_pkg;

    // bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    // register byte addresses, one aligned word each
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_CNT_LO = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_CNT_HI = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_RLD_LO = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_RLD_HI = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_CLKCTL = 5'h14;
    localparam logic [ADDR_W-1:0] OFF_INTEN  = 5'h18;

    // timer_control_register fields
    localparam int CTL_HIGH_OVF = 7;
    localparam int CTL_LOW_OVF  = 6;
    localparam int CTL_LOW_IEN  = 5;
    localparam int CTL_CAP_EN   = 4;
    localparam int CTL_SPLIT    = 3;
    localparam int CTL_RUN      = 2;
    localparam int CTL_EXT_SEL  = 0;
    localparam logic [7:0] CTL_WR_MASK = 8'hfd;

    // clock_control_register and interrupt_enable_register fields
    localparam int CKC_LOW_SEL  = 4;
    localparam int CKC_HIGH_SEL = 5;
    localparam int IEN_TIMER    = 5;

    // reset values and count limits
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [7:0]  BYTE_MAX = 8'hff;
    localparam logic [15:0] WORD_MAX = 16'hffff;

    // prescaler terminal counts: core / 12, external / 8
    localparam logic [3:0] CORE_DIV_LAST = 4'hb;
    localparam logic [2:0] EXT_DIV_LAST  = 3'h7;

endpackage

// >>> arlt_timer.sv
// auto-reload timer with split mode and slow-oscillator capture
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module arlt_timer (
    // clock, reset, enable
    input  wire logic                            clk,
    input  wire logic                            rst,
    input  wire logic                            ce,
    // avalon-mm slave
    input  wire logic [arlt_pkg::ADDR_W-1:0]     avsAddress,
    input  wire logic                            avsRead,
    input  wire logic                            avsWrite,
    input  wire logic [arlt_pkg::DATA_W-1:0]     avsWritedata,
    input  wire logic [3:0]                      avsByteenable,
    output var  logic [arlt_pkg::DATA_W-1:0]     avsReaddata,
    output var  logic                            avsWaitrequest,
    // clock sources
    input  wire logic                            extOsc,
    input  wire logic                            slowOsc,
    // interrupt request
    output var  logic                            timerIrq
);
    import arlt_pkg::*;

    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [7:0]  clkCtl_r;
    logic [7:0]  intEn_r;
    logic [7:0]  cntLo_r;
    logic [7:0]  cntLo_nxt;
    logic [7:0]  cntHi_r;
    logic [7:0]  cntHi_nxt;
    logic [7:0]  rldLo_r;
    logic [7:0]  rldLo_nxt;
    logic [7:0]  rldHi_r;
    logic [7:0]  rldHi_nxt;
    logic [7:0]  rdByte;
    logic [7:0]  wByte;
    logic        wrAcc;
    logic        wrCtrl;
    logic        wrCntLo;
    logic        wrCntHi;
    logic        wrRldLo;
    logic        wrRldHi;
    logic        wrClkCtl;
    logic        wrIntEn;
    logic        extSync1_r;
    logic        extSync2_r;
    logic        extPrev_r;
    logic [2:0]  extDiv_r;
    logic        extRise;
    logic        tickExt;
    logic        slowSync1_r;
    logic        slowSync2_r;
    logic        slowPrev_r;
    logic        capStrobe_r;
    logic [3:0]  coreDiv_r;
    logic        tickCore12;
    logic        lowTick;
    logic        highTick;
    logic        setHigh;
    logic        setLow;
    logic        runBit;
    logic        splitBit;
    logic [15:0] cntWord;

    // ---------------------------------------------------------------
    // register bus
    // ---------------------------------------------------------------

    // a write lands only at the edge where waitrequest is seen low
    assign wrAcc    = avsWrite & ~avsWaitrequest & avsByteenable[0];
    assign wByte    = avsWritedata[7:0];
    assign wrCtrl   = wrAcc && (avsAddress == OFF_CTRL);
    assign wrCntLo  = wrAcc && (avsAddress == OFF_CNT_LO);
    assign wrCntHi  = wrAcc && (avsAddress == OFF_CNT_HI);
    assign wrRldLo  = wrAcc && (avsAddress == OFF_RLD_LO);
    assign wrRldHi  = wrAcc && (avsAddress == OFF_RLD_HI);
    assign wrClkCtl = wrAcc && (avsAddress == OFF_CLKCTL);
    assign wrIntEn  = wrAcc && (avsAddress == OFF_INTEN);

    // read mux; unmapped addresses read as zero
    always_comb begin
        if (avsAddress == OFF_CTRL) begin
            rdByte = ctrl_r & CTL_WR_MASK; // R20
        end else if (avsAddress == OFF_CNT_LO) begin
            rdByte = cntLo_r;
        end else if (avsAddress == OFF_CNT_HI) begin
            rdByte = cntHi_r;
        end else if (avsAddress == OFF_RLD_LO) begin
            rdByte = rldLo_r;
        end else if (avsAddress == OFF_RLD_HI) begin
            rdByte = rldHi_r;
        end else if (avsAddress == OFF_CLKCTL) begin
            rdByte = clkCtl_r;
        end else if (avsAddress == OFF_INTEN) begin
            rdByte = intEn_r;
        end else begin
            rdByte = RST_BYTE;
        end
    end

    // waitrequest idles high and drops for exactly one cycle per access,
    // which keeps the slave answer fixed at one wait state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avsWaitrequest <= 1'b1;
        end else if (ce) begin
            if ((avsRead | avsWrite) && avsWaitrequest) begin
                avsWaitrequest <= 1'b0;
            end else begin
                avsWaitrequest <= 1'b1;
            end
        end
    end

    // read data captured as waitrequest drops, stands while it is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avsReaddata <= '0;
        end else if (ce) begin
            if (avsRead && avsWaitrequest) begin
                avsReaddata <= {24'h000000, rdByte};
            end
        end
    end

    // plain configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clkCtl_r <= RST_BYTE;
            intEn_r  <= RST_BYTE;
        end else if (ce) begin
            if (wrClkCtl) begin
                clkCtl_r <= wByte;
            end
            if (wrIntEn) begin
                intEn_r <= wByte;
            end
        end
    end

    // ---------------------------------------------------------------
    // clock sources
    // ---------------------------------------------------------------

    // core clock / 12 prescaler, free running
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coreDiv_r <= 4'h0;
        end else if (ce) begin
            if (coreDiv_r == CORE_DIV_LAST) begin
                coreDiv_r <= 4'h0;
            end else begin
                coreDiv_r <= coreDiv_r + 4'h1;
            end
        end
    end
    assign tickCore12 = (coreDiv_r == CORE_DIV_LAST);

    // external osc: two-stage sync, then rising edges divided by 8;
    // the osc must run below half the core rate or edges are lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extSync1_r <= 1'b0;
            extSync2_r <= 1'b0;
            extPrev_r  <= 1'b0;
            extDiv_r   <= 3'h0;
        end else if (ce) begin
            extSync1_r <= extOsc;     // R4
            extSync2_r <= extSync1_r; // R4
            extPrev_r  <= extSync2_r;
            if (extRise) begin
                extDiv_r <= extDiv_r + 3'h1;
            end
        end
    end
    assign extRise = extSync2_r & ~extPrev_r;
    assign tickExt = extRise && (extDiv_r == EXT_DIV_LAST); // R3

    // slow osc: sync, then one registered strobe per falling edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            slowSync1_r <= 1'b0;
            slowSync2_r <= 1'b0;
            slowPrev_r  <= 1'b0;
            capStrobe_r <= 1'b0;
        end else if (ce) begin
            slowSync1_r <= slowOsc;                   // R21
            slowSync2_r <= slowSync1_r;               // R21
            slowPrev_r  <= slowSync2_r;
            capStrobe_r <= slowPrev_r & ~slowSync2_r; // R21
        end
    end

    // per-byte tick select; 16-bit and capture modes use the low select
    assign lowTick  = clkCtl_r[CKC_LOW_SEL] ? 1'b1 :
                      (ctrl_r[CTL_EXT_SEL] ? tickExt : tickCore12); // R10 R17
    assign highTick = clkCtl_r[CKC_HIGH_SEL] ? 1'b1 :
                      (ctrl_r[CTL_EXT_SEL] ? tickExt : tickCore12); // R10

    // ---------------------------------------------------------------
    // counter, reload and flags
    // ---------------------------------------------------------------

    assign runBit   = ctrl_r[CTL_RUN];
    assign splitBit = ctrl_r[CTL_SPLIT];
    assign cntWord  = {cntHi_r, cntLo_r}; // R1

    // next count; reload replaces the rollover value in the same cycle
    always_comb begin
        cntLo_nxt = cntLo_r;
        cntHi_nxt = cntHi_r;
        setHigh   = 1'b0;
        setLow    = 1'b0;
        if (splitBit) begin
            if (lowTick) begin                           // R9
                if (cntLo_r == BYTE_MAX) begin
                    cntLo_nxt = rldLo_r;                 // R8 R22
                    setLow    = 1'b1;                    // R11
                end else begin
                    cntLo_nxt = cntLo_r + 8'h01;
                end
            end
            if (runBit && highTick) begin                // R9
                if (cntHi_r == BYTE_MAX) begin
                    cntHi_nxt = rldHi_r;                 // R8 R22
                    setHigh   = 1'b1;                    // R11
                end else begin
                    cntHi_nxt = cntHi_r + 8'h01;
                end
            end
        end else if (runBit && lowTick) begin            // R2
            if (cntWord == WORD_MAX) begin
                {cntHi_nxt, cntLo_nxt} = {rldHi_r, rldLo_r}; // R5 R22
                setHigh = 1'b1;                          // R5
                setLow  = 1'b1;
            end else begin
                {cntHi_nxt, cntLo_nxt} = cntWord + 16'h0001;
                setLow = (cntLo_r == BYTE_MAX);          // R7
            end
        end
        // capture raises the high flag too
        if (ctrl_r[CTL_CAP_EN] && capStrobe_r) begin
            setHigh = 1'b1;                              // R16
        end
        // software write to a count byte wins over counting
        if (wrCntLo) begin
            cntLo_nxt = wByte;
        end
        if (wrCntHi) begin
            cntHi_nxt = wByte;
        end
    end

    // reload pair; a capture overrides a software write in the same cycle
    always_comb begin
        rldLo_nxt = wrRldLo ? wByte : rldLo_r;
        rldHi_nxt = wrRldHi ? wByte : rldHi_r;
        if (ctrl_r[CTL_CAP_EN] && capStrobe_r) begin
            rldLo_nxt = cntLo_r; // R16
            rldHi_nxt = cntHi_r; // R16
        end
    end

    // control: a hardware set wins over a software clear in one cycle
    always_comb begin
        ctrl_nxt = wrCtrl ? (wByte & CTL_WR_MASK) : ctrl_r; // R19 R20
        ctrl_nxt[CTL_HIGH_OVF] = ctrl_nxt[CTL_HIGH_OVF] | setHigh; // R13
        ctrl_nxt[CTL_LOW_OVF]  = ctrl_nxt[CTL_LOW_OVF] | setLow;   // R13
    end

    // timer state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r  <= RST_BYTE; // R19
            cntLo_r <= RST_BYTE;
            cntHi_r <= RST_BYTE;
            rldLo_r <= RST_BYTE;
            rldHi_r <= RST_BYTE;
        end else if (ce) begin
            ctrl_r  <= ctrl_nxt;
            cntLo_r <= cntLo_nxt;
            cntHi_r <= cntHi_nxt;
            rldLo_r <= rldLo_nxt;
            rldHi_r <= rldHi_nxt;
        end
    end

    // level request while any enabled flag stands; the request is shared, so
    // the handler must read both to tell the source apart
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timerIrq <= 1'b0;
        end else if (ce) begin
            timerIrq <= intEn_r[IEN_TIMER] &
                        (ctrl_r[CTL_HIGH_OVF] |
                         (ctrl_r[CTL_LOW_IEN] & ctrl_r[CTL_LOW_OVF])); // R6 R7 R12
        end
    end

endmodule // arlt_timer

`default_nettype wire

// >>> arlt_timer_checker.sv
// checker for the timer's bus handshake and interrupt port
`timescale 1ns/1ps
`default_nettype none

module arlt_timer_checker (
    // clock, reset, enable
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        ce,
    // avalon-mm slave
    input wire logic [arlt_pkg::ADDR_W-1:0] avsAddress,
    input wire logic                        avsRead,
    input wire logic                        avsWrite,
    input wire logic [arlt_pkg::DATA_W-1:0] avsWritedata,
    input wire logic [3:0]                  avsByteenable,
    input wire logic [arlt_pkg::DATA_W-1:0] avsReaddata,
    input wire logic                        avsWaitrequest,
    // clock sources and interrupt
    input wire logic                        extOsc,
    input wire logic                        slowOsc,
    input wire logic                        timerIrq
);
    import arlt_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic req;
    // a request seen while the slave still holds waitrequest
    assign req = ce && (avsRead || avsWrite) && avsWaitrequest;

    wait_one_a: assert property (req |=> !avsWaitrequest)
        else $error("request not answered after one wait cycle");
    wait_once_a: assert property (ce && !avsWaitrequest |=> avsWaitrequest)
        else $error("waitrequest low for more than one cycle");
    idle_wait_a: assert property (ce && !avsRead && !avsWrite |=> avsWaitrequest)
        else $error("waitrequest low without a request");
    upper_zero_a: assert property (avsReaddata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    bit1_zero_a: assert property (
        req && avsRead && avsAddress == OFF_CTRL |=> avsReaddata[1] == 1'b0)
        else $error("control bit one read as one");
    bad_addr_a: assert property (req && avsRead && avsAddress > OFF_INTEN
        |=> avsReaddata == '0)
        else $error("unmapped address read nonzero");
    read_hold_a: assert property (!(req && avsRead) |=> $stable(avsReaddata))
        else $error("read data changed without a read");
    // masking the timer interrupt drops the request two edges on
    irq_mask_a: assert property (
        ce && avsWrite && !avsWaitrequest
        && avsByteenable[0] && avsAddress == OFF_INTEN
        && !avsWritedata[IEN_TIMER] ##1 ce |=> !timerIrq)
        else $error("interrupt request stayed up after masking");

    irq_seen_c: cover property (!timerIrq ##1 timerIrq);
    ctl_read_c: cover property (req && avsRead && avsAddress == OFF_CTRL);
    bad_read_c: cover property (req && avsRead && avsAddress > OFF_INTEN);
    cap_fall_c: cover property ($fell(slowOsc));
    ext_rise_c: cover property ($rose(extOsc));
endmodule // arlt_timer_checker

bind arlt_timer arlt_timer_checker i_chk (.clk, .rst, .ce, .avsAddress,
    .avsRead, .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata,
    .avsWaitrequest, .extOsc, .slowOsc, .timerIrq);

`default_nettype wire

// >>> tb.sv
// self-checking bench for the auto-reload timer
`timescale 1ns/1ps
`default_nettype none

module tb;
    import arlt_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              ce = 1'b1;
    logic [ADDR_W-1:0] avsAddress = '0;
    logic              avsRead = 1'b0;
    logic              avsWrite = 1'b0;
    logic [DATA_W-1:0] avsWritedata = '0;
    logic [3:0]        avsByteenable = 4'hf;
    logic [DATA_W-1:0] avsReaddata;
    logic              avsWaitrequest;
    logic              extOsc = 1'b0;
    logic              slowOsc = 1'b1;
    logic              timerIrq;
    logic [7:0]        q;
    logic [7:0]        qq;
    int                fail_count = 0;
    int                checks_done = 0;
    int                n;
    int                k;
    int                cyc = 0; // free cycle stamp for capture spacing
    int                m [0:7]; // model of what software last wrote

    arlt_timer i_dut (.clk, .rst, .ce, .avsAddress, .avsRead, .avsWrite,
        .avsWritedata, .avsByteenable, .avsReaddata, .avsWaitrequest,
        .extOsc, .slowOsc, .timerIrq);

    initial begin
        forever #50 clk = ~clk;
    end

    // cycle stamp, read before its own update at each edge
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    task automatic stop_test;
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask

    // one access, held until waitrequest is sampled low at an edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        n = 0;
        @(posedge clk);
        avsRead <= ~wr;
        avsWrite <= wr;
        avsAddress <= a;
        avsWritedata <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            fail_count++;
            stop_test();
        end
        q = avsReaddata[7:0];
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (wr && avsByteenable[0] && a <= OFF_INTEN) begin
            m[a / 4] = int'(d);
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk($sformatf("register %h", a), e, q);
    endtask

    // bounded wait, the irq can take a full low-byte lap
    task automatic wait_irq;
        n = 0;
        while (timerIrq !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        if (n >= 600) begin
            fail_count++;
            stop_test();
        end
    endtask

    initial begin
        n = $urandom(12);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(5'(i * 4), 8'(m[i]));
        end
        bus(1'b1, OFF_CTRL, 8'h3f);
        rd(OFF_CTRL, 8'h3d);
        avsByteenable <= 4'he;
        bus(1'b1, OFF_CTRL, 8'h00);
        avsByteenable <= 4'hf;
        rd(OFF_CTRL, 8'h3d);
        // external clock: eight synchronised rises per count
        k = 1 + ($urandom % 6);
        bus(1'b1, OFF_CTRL, 8'h05);
        repeat (16 * k) begin
            repeat (2) @(posedge clk);
            extOsc <= ~extOsc;
        end
        repeat (6) @(posedge clk);
        bus(1'b1, OFF_CTRL, 8'h00);
        rd(OFF_CNT_LO, 8'(k));
        bus(1'b1, OFF_CNT_LO, 8'h00);
        bus(1'b1, OFF_CTRL, 8'h04);
        repeat (240) @(posedge clk);
        bus(1'b1, OFF_CTRL, 8'h00);
        bus(1'b0, OFF_CNT_LO, 8'h00);
        chk("div12 count", 8'h01, {7'h0, q >= 8'h13 && q <= 8'h15});
        // 16-bit mode, low byte rollover only
        bus(1'b1, OFF_RLD_LO, 8'h34);
        bus(1'b1, OFF_RLD_HI, 8'h12);
        bus(1'b1, OFF_CNT_LO, 8'hf0);
        bus(1'b1, OFF_CNT_HI, 8'h10);
        bus(1'b1, OFF_CLKCTL, 8'h10);
        bus(1'b1, OFF_INTEN, 8'h20);
        bus(1'b1, OFF_CTRL, 8'h24);
        wait_irq();
        rd(OFF_CTRL, 8'h64);
        bus(1'b1, OFF_INTEN, 8'h00);
        repeat (2) @(posedge clk);
        chk("irq masked", 8'h00, {7'h0, timerIrq});
        rd(OFF_CTRL, 8'h64);
        // full rollover reloads the pair
        bus(1'b1, OFF_CNT_HI, 8'hff);
        bus(1'b1, OFF_CTRL, 8'h04);
        bus(1'b1, OFF_INTEN, 8'h20);
        wait_irq();
        rd(OFF_CTRL, 8'hc4);
        rd(OFF_CNT_HI, 8'(m[4]));
        // split mode, run held off for the high byte, then set
        bus(1'b1, OFF_CTRL, 8'h00);
        bus(1'b1, OFF_CLKCTL, 8'h30);
        bus(1'b1, OFF_RLD_LO, 8'h80);
        bus(1'b1, OFF_RLD_HI, 8'h55);
        bus(1'b1, OFF_CNT_HI, 8'h77);
        bus(1'b1, OFF_CTRL, 8'h08);
        repeat (300) @(posedge clk);
        chk("split irq", 8'h00, {7'h0, timerIrq});
        rd(OFF_CNT_HI, 8'h77);
        rd(OFF_CTRL, 8'h48);
        bus(1'b1, OFF_CTRL, 8'h2c);
        repeat (200) @(posedge clk);
        chk("split irq", 8'h01, {7'h0, timerIrq});
        rd(OFF_CTRL, 8'hec);
        bus(1'b1, OFF_CTRL, 8'h28);
        bus(1'b0, OFF_CNT_HI, 8'h00);
        chk("high reload", 8'h01, {7'h0, q >= 8'h55 && q < 8'hc0});
        // capture on the slow oscillator's falling edge
        bus(1'b1, OFF_CTRL, 8'h00);
        bus(1'b1, OFF_INTEN, 8'h00);
        bus(1'b1, OFF_CLKCTL, 8'h10);
        bus(1'b1, OFF_CNT_LO, 8'h00);
        bus(1'b1, OFF_CNT_HI, 8'h00);
        bus(1'b1, OFF_CTRL, 8'h14);
        repeat (50) @(posedge clk);
        slowOsc <= 1'b0;
        k = cyc;
        repeat (6) @(posedge clk);
        rd(OFF_CTRL, 8'h94);
        rd(OFF_RLD_HI, 8'h00);
        bus(1'b0, OFF_RLD_LO, 8'h00);
        qq = q;
        chk("capture", 8'h01, {7'h0, q > 8'h30 && q < 8'h40});
        repeat (20) @(posedge clk);
        rd(OFF_RLD_LO, qq);
        // second falling edge: capture step equals core cycles between falls
        slowOsc <= 1'b1;
        repeat (10) @(posedge clk);
        slowOsc <= 1'b0;
        k = cyc - k;
        repeat (6) @(posedge clk);
        bus(1'b0, OFF_RLD_LO, 8'h00);
        chk("capture step", 8'(k), q - qq);
        stop_test();
    end
endmodule // tb

`default_nettype wire
